//--- src/pcrc_top.sv
// programmable crc generator: fifo-fed serial lfsr with software polynomial
// How it works
// - four-bit length input sets polynomial degree as value plus one.
// - term-select input covers polynomial positions fifteen down to one.
// - set bit n of term select feeds back into x^n tap, for n up to the length value; higher bits are ignored.
// - constant term always fed back, no bit selects it.
// - top term implied by length, so term select lacks it.
module pcrc_top #(
  parameter int DATA_W = pcrc_pkg::DATA_W,
  parameter int DEPTH = pcrc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] polyLengthField,
  input wire logic [15:1] polyTermRegister,
  input wire logic crcClear,
  input wire logic [DATA_W-1:0] wordData,
  input wire logic wordValid,
  output logic wordReady,
  output logic [15:0] crcResult,
  output logic crcBusy,
  output logic wordDone
);
  typedef enum logic [1:0] {
    PCRC_IDLE = 2'b01,
    PCRC_SHIFT = 2'b10
  } pcrc_state_t;

  pcrc_state_t state_q;
  logic [15:0] lfsr_q;
  logic [15:0] lfsr_d;
  logic [DATA_W-1:0] shReg_q;
  logic [pcrc_pkg::CNT_W-1:0] bitCnt_q;
  logic [DATA_W-1:0] fifoData;
  logic fifoValid;
  logic fifoReady;
  logic fifoInReady;
  logic [15:0] tapMask;
  logic feedBit;
  logic [3:0] lenSel;
  logic crcBusy_q;
  logic wordDone_q;
  logic wordReady_q;
  logic fifoInValid;
  localparam int RUN_W = pcrc_pkg::CNT_W + 1;
  logic [RUN_W-1:0] runLen_q;

  // elaboration check: shift register needs at least two bits
  if (DATA_W < 2 || DATA_W > 16)
    $error("pcrc_top: DATA_W must be 2 to 16");

  function automatic logic [15:0] tap_mask(input logic [15:1] terms, input logic [3:0] len);
    logic [15:0] m;
    m = {terms, 1'b1};
    for (int i = 1; i < 16; i++)
      if (i > int'(len))
        m[i] = 1'b0;
    return m;
  endfunction

  pcrc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .inData(wordData),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady)
  );

  assign lenSel = polyLengthField;
  assign tapMask = tap_mask(polyTermRegister, lenSel);
  assign fifoReady = (state_q == PCRC_IDLE) && !crcClear;
  // only words offered against the registered ready enter the fifo
  assign fifoInValid = wordValid && wordReady_q;
  // outgoing bit is lfsr top for selected length, xored with data msb
  assign feedBit = lfsr_q[lenSel] ^ shReg_q[DATA_W-1];

  always_comb
  begin
    lfsr_d = {lfsr_q[14:0], 1'b0};
    for (int i = 0; i < 16; i++)
      if (tapMask[i])
        lfsr_d[i] = lfsr_d[i] ^ feedBit;
    for (int i = 1; i < 16; i++)
      if (i > int'(lenSel))
        lfsr_d[i] = 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= PCRC_IDLE;
      bitCnt_q <= '0;
      shReg_q <= '0;
    end
    else
    begin
      case (state_q)
        PCRC_IDLE:
        begin
          if (fifoValid && fifoReady)
          begin
            shReg_q <= fifoData;
            bitCnt_q <= pcrc_pkg::CNT_W'(DATA_W - 1);
            state_q <= PCRC_SHIFT;
          end
        end
        PCRC_SHIFT:
        begin
          shReg_q <= {shReg_q[DATA_W-2:0], 1'b0};
          if (bitCnt_q == '0)
            state_q <= PCRC_IDLE;
          else
            bitCnt_q <= bitCnt_q - 1'b1;
        end
        default:
          state_q <= PCRC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lfsr_q <= pcrc_pkg::CRC_RESET;
    else if (crcClear && state_q == PCRC_IDLE)
      lfsr_q <= pcrc_pkg::CRC_RESET;
    else if (state_q == PCRC_SHIFT)
      lfsr_q <= lfsr_d;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      crcBusy_q <= 1'b0;
      wordDone_q <= 1'b0;
      wordReady_q <= 1'b0;
    end
    else
    begin
      crcBusy_q <= (state_q == PCRC_SHIFT) || fifoValid;
      wordDone_q <= (state_q == PCRC_SHIFT) && (bitCnt_q == '0);
      // drop ready after each write so a full fifo is never promised a slot
      wordReady_q <= fifoInReady && !fifoInValid;
    end
  end

  // length of the current shift run, read only by the checks below
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      runLen_q <= '0;
    else if (state_q == PCRC_SHIFT)
      runLen_q <= runLen_q + 1'b1;
    else
      runLen_q <= '0;
  end

  assign crcResult = lfsr_q;
  assign crcBusy = crcBusy_q;
  assign wordDone = wordDone_q;
  assign wordReady = wordReady_q;

  word_bits_a: assert property (@(posedge clk) disable iff (reset)
    $rose(state_q == PCRC_SHIFT) |-> (state_q == PCRC_SHIFT) [*2])
    else $error("word shift shorter than expected");
  shift_step_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PCRC_SHIFT && !crcClear) |=> lfsr_q == $past(lfsr_d))
    else $error("lfsr did not advance");
  const_term_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PCRC_SHIFT && feedBit) |=> lfsr_q[0])
    else $error("constant term not fed back");
  no_feed_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PCRC_SHIFT && !feedBit) |=> !lfsr_q[0])
    else $error("bit zero set without feedback");
  tap_sel_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PCRC_SHIFT && feedBit && polyLengthField == 4'hf && polyTermRegister[12])
    |=> lfsr_q[12] != $past(lfsr_q[11]))
    else $error("selected tap not applied");
  tap_off_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PCRC_SHIFT && polyLengthField == 4'hf && !polyTermRegister[5])
    |=> lfsr_q[5] == $past(lfsr_q[4]))
    else $error("unselected tap applied");
  len_mask_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PCRC_SHIFT && polyLengthField == 4'h7) |=> lfsr_q[15:8] == 8'h00)
    else $error("bits above length not cleared");
  done_pulse_a: assert property (@(posedge clk) disable iff (reset)
    wordDone |=> !wordDone)
    else $error("done held longer than one cycle");

  sequence pop_word_s;
    state_q == PCRC_IDLE && fifoValid && fifoReady;
  endsequence
  sequence last_bit_s;
    state_q == PCRC_SHIFT && bitCnt_q == '0;
  endsequence

  pop_load_a: assert property (@(posedge clk) disable iff (reset)
    pop_word_s |=> state_q == PCRC_SHIFT && shReg_q == $past(fifoData))
    else $error("popped word not loaded");
  last_done_a: assert property (@(posedge clk) disable iff (reset)
    last_bit_s |=> wordDone && state_q == PCRC_IDLE)
    else $error("done missing after last bit");
  word_len_a: assert property (@(posedge clk) disable iff (reset)
    wordDone |-> runLen_q == RUN_W'(DATA_W))
    else $error("word shifted wrong number of bits");
  ready_safe_a: assert property (@(posedge clk) disable iff (reset)
    wordReady |-> fifoInReady)
    else $error("ready shown with fifo full");
  clear_idle_a: assert property (@(posedge clk) disable iff (reset)
    (crcClear && state_q == PCRC_IDLE) |=> lfsr_q == pcrc_pkg::CRC_RESET && state_q == PCRC_IDLE)
    else $error("idle clear did not empty crc");
  clear_shift_a: assert property (@(posedge clk) disable iff (reset)
    (crcClear && state_q == PCRC_SHIFT) |=> lfsr_q == $past(lfsr_d))
    else $error("clear disturbed a shift");
  top_term_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PCRC_SHIFT && polyLengthField == 4'hf && lfsr_q[15] && !shReg_q[DATA_W-1]) |=> lfsr_q[0])
    else $error("implied top term not fed back");
endmodule

//--- src/pcrc_pkg.sv
// shared constants for the programmable crc generator
package pcrc_pkg;
  localparam int LEN_W = 4;
  localparam int TERM_LO = 1;
  localparam int TERM_HI = 15;
  localparam int MAX_W = 16;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] LEN_RESET = 4'h0;
  localparam logic [15:1] TERM_RESET = 15'h0000;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  localparam int CNT_W = 5;
endpackage

//--- src/pcrc_fifo.sv
// flip-flop fifo with valid and ready on both sides
module pcrc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic doWrite;
  logic doRead;

  // elaboration check: pointers wrap naturally only for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("pcrc_fifo: DEPTH must be a power of two, at least 2");

  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem_q[wrPtr_q] <= inData;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (doRead)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (doWrite && !doRead)
        count_q <= count_q + 1'b1;
      else if (doRead && !doWrite)
        count_q <= count_q - 1'b1;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (reset) count_q <= DEPTH[AW:0])
    else $error("fifo count above depth");
endmodule

//--- verif/testbench.sv
// self-checking bench for the programmable crc generator
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic reset = 1'b1;
  logic [3:0] len = 4'hf;
  logic [15:1] taps = 15'h0000;
  logic clr = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic wv = 1'b0;
  logic wordReady;
  logic [15:0] crcResult;
  logic crcBusy;
  logic wordDone;
  logic [15:0] model;
  int bad_count = 0;
  int num_checks = 0;
  pcrc_top pcrc_top_i (.clk(clk), .reset(reset), .polyLengthField(len), .polyTermRegister(taps),
    .crcClear(clr), .wordData(wd), .wordValid(wv), .wordReady(wordReady), .crcResult(crcResult),
    .crcBusy(crcBusy), .wordDone(wordDone));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // serial msb-first reference, init zero, bits above degree dropped
  function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] m;
    logic fb;
    m = 16'hffff >> (15 - len);
    for (int i = 15; i >= 0; i--)
    begin
      fb = c[len] ^ w[i];
      c = (c << 1) ^ (fb ? {taps, 1'b1} : 16'h0000);
      c = c & m;
    end
    return c;
  endfunction
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic set_poly(input logic [3:0] l, input logic [15:1] t);
    len = l;
    taps = t;
    clr = 1'b1;
    model = 16'h0000;
    @(posedge clk);
    #1 clr = 1'b0;
  endtask
  task automatic push(input logic [15:0] w);
    int n;
    wd = w;
    wv = 1'b1;
    model = ref_crc(model, w);
    n = 0;
    @(negedge clk);
    while (wordReady !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 100)
    begin
      bad_count++;
      give_verdict();
    end
    @(posedge clk);
    #1;
  endtask
  task automatic wait_done(input int k);
    int n;
    int d;
    wv = 1'b0;
    d = 0;
    for (n = 0; n < 40 * k && d < k; n++)
    begin
      @(negedge clk);
      if (wordDone === 1'b1)
        d++;
    end
    if (d < k)
    begin
      bad_count++;
      give_verdict();
    end
    check("crcResult", model, crcResult);
  endtask
  task automatic test_ccitt();
    set_poly(4'hf, 15'h0810);
    push(16'h1234);
    push(16'hbeef);
    wait_done(2);
    $display("test ccitt done");
  endtask
  task automatic test_short();
    set_poly(4'h7, 15'h0803);
    push(16'hc3a5);
    wait_done(1);
    set_poly(4'h4, 15'h0004);
    push(16'h7001);
    wait_done(1);
    $display("test short done");
  endtask
  task automatic test_const();
    set_poly(4'hf, 15'h0000);
    push(16'h8001);
    wv = 1'b0;
    repeat (3) @(posedge clk);
    #1 clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    wait_done(1);
    $display("test const done");
  endtask
  task automatic test_fill();
    set_poly(4'hf, 15'h4002);
    clr = 1'b1;
    for (int i = 0; i < 16; i++)
      push(16'h1111 * i[15:0] + 16'h0f0f);
    wv = 1'b0;
    @(negedge clk);
    check("wordReady", 16'h0000, {15'h0000, wordReady});
    check("crcBusy", 16'h0001, {15'h0000, crcBusy});
    @(posedge clk);
    #1 clr = 1'b0;
    wait_done(16);
    @(negedge clk);
    check("crcBusy", 16'h0000, {15'h0000, crcBusy});
    $display("test fill done");
  endtask
  task automatic test_reset();
    set_poly(4'hf, 15'h0810);
    push(16'ha55a);
    wv = 1'b0;
    repeat (4) @(posedge clk);
    #1 reset = 1'b1;
    @(negedge clk);
    check("crcResult", 16'h0000, crcResult);
    check("crcBusy", 16'h0000, {15'h0000, crcBusy});
    check("wordReady", 16'h0000, {15'h0000, wordReady});
    @(posedge clk);
    #1 reset = 1'b0;
    model = 16'h0000;
    push(16'h0001);
    wait_done(1);
    $display("test reset done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    check("crcResult", 16'h0000, crcResult);
    test_ccitt();
    test_short();
    test_const();
    test_fill();
    test_reset();
    give_verdict();
  end
endmodule
